// *** rtl/adcc_top.sv ***
// conversion control block with ahb-lite register slave
// Overview of operation
// - writing status/control 1 aborts conversion; unless channel is all ones, with software trigger it starts new, with hardware trigger it arms
// - compare off: done flag sets at end of every conversion
// - compare on: done flag sets only when compare condition is true
// - done flag bit 7 is read-only; writes never set it
// - done flag clears on status/control 1 write or result low byte read
// - interrupt raised when flag sets while interrupt enable bit 6 is one and the done bit of the interrupt mask is set
// - continuous bit 5 zero: one conversion per write or per trigger
// - continuous bit one: back-to-back conversions after write or trigger event
// - five-bit channel field in bits 4:0 chooses converted input
// - codes 0..27 select analog inputs, 29 high ref, 30 low ref, 28 reserved
// - all-ones channel powers converter off and isolates the input
// - all-ones channel written in continuous mode stops with no extra conversion
// - single mode returns to low power after each conversion
// - trigger select picks register write or hardware trigger input as start
// - compare enable bit switches the compare function on or off
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
module adcc_top
	import adcc_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DFLT
)(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// trigger from periodic counter
	input wire logic hardware_trigger_in,
	// analog converter
	input wire logic [9:0] ana_result,
	output logic conv_power_on,
	output logic conv_active,
	output logic [4:0] ain_select,
	output logic ref_high_sel,
	output logic ref_low_sel,
	output logic input_isolate,
	// interrupt
	output logic irq
);
	// channel code to source kind
	function automatic adcc_src_e chan_kind(input logic [4:0] ch);
		if (ch <= CH_LAST_AIN)
			return SRC_AIN;
		else if (ch == CH_REFERENCE_HIGH)
			return SRC_REFH;
		else if (ch == CH_REFERENCE_LOW)
			return SRC_REFL;
		else if (ch == CH_OFF)
			return SRC_OFF;
		else
			return SRC_RSVD;
	endfunction : chan_kind

	logic rst_meta_ff;
	logic rst_n;
	logic trig_s1_ff;
	logic trig_s2_ff;
	logic trig_s3_ff;
	logic trig_lvl_ff;
	logic trig_evt;
	logic wr_pend_ff;
	logic [7:0] addr_ff;
	logic flag_ff;
	logic ien_ff;
	logic cont_ff;
	logic [4:0] ch_ff;
	logic trig_sel_ff;
	logic cmp_en_ff;
	logic cmp_gt_ff;
	logic [9:0] cmpv_ff;
	logic [9:0] res_ff;
	logic [IRQ_BITS-1:0] ists_ff;
	logic [IRQ_BITS-1:0] imsk_ff;
	adcc_state_e st_ff;
	adcc_state_e nxt_st;
	logic addr_take;
	logic rd_take;
	logic sc1_wr;
	logic wr_ch_on;
	logic resl_rd;
	logic cmp_hit;
	logic flag_set;
	logic start_wr;
	logic start_trig;
	logic start_cont;
	adcc_src_e src;
	adcc_conv_if cv();

	// reset release through two flops
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// trigger pin: three flops, a change counts when stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_s1_ff <= 1'b0;
			trig_s2_ff <= 1'b0;
			trig_s3_ff <= 1'b0;
			trig_lvl_ff <= 1'b0;
		end
		else
		begin
			trig_s1_ff <= hardware_trigger_in;
			trig_s2_ff <= trig_s1_ff;
			trig_s3_ff <= trig_s2_ff;
			if (trig_s2_ff == trig_s3_ff)
				trig_lvl_ff <= trig_s3_ff;
		end
	end
	assign trig_evt = trig_s2_ff && trig_s3_ff && !trig_lvl_ff;

	// bus slave: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_take = hsel && hready && htrans[1];
	assign rd_take = addr_take && !hwrite;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end
		else
		begin
			wr_pend_ff <= addr_take && hwrite;
			if (addr_take)
				addr_ff <= {haddr[7:2], 2'b00};
		end
	end

	// read data is muxed from flops by the address held from the address phase
	always_comb
	begin
		hrdata = 32'h0000_0000;
		case (addr_ff)
			OFS_SC1: hrdata[7:0] = {flag_ff, ien_ff, cont_ff, ch_ff};
			OFS_SC2: hrdata[7:0] = {cv.busy, trig_sel_ff, cmp_en_ff, cmp_gt_ff, 4'h0};
			OFS_RESH: hrdata[1:0] = res_ff[9:8];
			OFS_RESL: hrdata[7:0] = res_ff[7:0];
			OFS_CMPV: hrdata[9:0] = cmpv_ff;
			OFS_ISTS: hrdata[IRQ_BITS-1:0] = ists_ff;
			OFS_IMSK: hrdata[IRQ_BITS-1:0] = imsk_ff;
			default: hrdata = 32'h0000_0000;
		endcase
	end

	assign sc1_wr = wr_pend_ff && (addr_ff == OFS_SC1);
	assign wr_ch_on = hwdata[SC1_CH_MSB:0] != CH_OFF;
	// side effect is taken at the address phase of the read
	assign resl_rd = rd_take && ({haddr[7:2], 2'b00} == OFS_RESL);

	// plain control fields; the flag bit of a write is dropped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ien_ff <= 1'b0;
			cont_ff <= 1'b0;
			ch_ff <= CH_RESET;
		end
		else if (sc1_wr)
		begin
			ien_ff <= hwdata[SC1_IEN_BIT];
			cont_ff <= hwdata[SC1_CONT_BIT];
			ch_ff <= hwdata[SC1_CH_MSB:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_sel_ff <= 1'b0;
			cmp_en_ff <= 1'b0;
			cmp_gt_ff <= 1'b0;
			cmpv_ff <= CMPV_RESET;
			imsk_ff <= '0;
		end
		else if (wr_pend_ff)
		begin
			case (addr_ff)
				OFS_SC2:
				begin
					trig_sel_ff <= hwdata[SC2_TRIG_BIT];
					cmp_en_ff <= hwdata[SC2_CMPEN_BIT];
					cmp_gt_ff <= hwdata[SC2_CMPGT_BIT];
				end
				OFS_CMPV: cmpv_ff <= hwdata[9:0];
				OFS_IMSK: imsk_ff <= hwdata[IRQ_BITS-1:0];
				default: ;
			endcase
		end
	end

	// starts: write in software mode, trigger when armed, or the next continuous pass
	assign start_wr = sc1_wr && wr_ch_on && !trig_sel_ff;
	assign start_trig = (st_ff == ST_ARMED) && trig_evt && trig_sel_ff && !sc1_wr;
	assign start_cont = (st_ff == ST_RUN) && cv.done && cont_ff && !sc1_wr;
	assign cv.start = start_wr || start_trig || start_cont;
	assign cv.abort = sc1_wr && cv.busy;

	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE, ST_ARMED:
			begin
				if (start_trig)
					nxt_st = ST_RUN;
			end
			ST_RUN:
			begin
				if (cv.done && !cont_ff)
					nxt_st = trig_sel_ff ? ST_ARMED : ST_IDLE;
			end
			default: nxt_st = ST_IDLE;
		endcase
		// a write overrides whatever the state was doing
		if (sc1_wr)
		begin
			if (!wr_ch_on)
				nxt_st = ST_IDLE;
			else if (trig_sel_ff)
				nxt_st = ST_ARMED;
			else
				nxt_st = ST_RUN;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= ST_IDLE;
		else
			st_ff <= nxt_st;
	end

	adcc_seq #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_seq (
		.clk(clk),
		.rst_n(rst_n),
		.cv(cv),
		.ana_result(ana_result)
	);

	adcc_cmp u_cmp (
		.result(cv.result),
		.level(cmpv_ff),
		.greater_eq(cmp_gt_ff),
		.hit(cmp_hit)
	);

	// result from the sequencer is valid one cycle after done
	logic done_d_ff;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			done_d_ff <= 1'b0;
		else
			done_d_ff <= cv.done;
	end

	assign flag_set = done_d_ff && (!cmp_en_ff || cmp_hit);

	// flag: set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_ff <= 1'b0;
		else if (flag_set)
			flag_ff <= 1'b1;
		else if (sc1_wr || resl_rd)
			flag_ff <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			res_ff <= 10'h000;
		else if (flag_set)
			res_ff <= cv.result;
	end

	// sticky events, write one to clear, set wins
	genvar gi;
	logic [IRQ_BITS-1:0] ev;
	assign ev[IRQ_DONE_BIT] = flag_set && ien_ff;
	assign ev[IRQ_ABORT_BIT] = cv.abort;
	generate
		for (gi = 0; gi < IRQ_BITS; gi++)
		begin : g_ists
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					ists_ff[gi] <= 1'b0;
				else if (ev[gi])
					ists_ff[gi] <= 1'b1;
				else if (wr_pend_ff && addr_ff == OFS_ISTS && hwdata[gi])
					ists_ff[gi] <= 1'b0;
			end
		end
	endgenerate
	assign irq = |(ists_ff & imsk_ff);

	// analog side: power only while converting, mux from the channel code
	assign src = chan_kind(ch_ff);
	assign conv_power_on = cv.busy && (src != SRC_OFF);
	assign conv_active = cv.busy;
	assign ain_select = (src == SRC_AIN) ? ch_ff : 5'h00;
	assign ref_high_sel = (src == SRC_REFH);
	assign ref_low_sel = (src == SRC_REFL);
	assign input_isolate = (src == SRC_OFF) || (src == SRC_RSVD);

	// checks
	sequence s_sw_write;
		sc1_wr && wr_ch_on && !trig_sel_ff;
	endsequence
	sequence s_conv_running;
		cv.busy && conv_active;
	endsequence
	a_write_starts: assert property (@(posedge clk) disable iff (!rst_n)
		s_sw_write |=> s_conv_running ##0 st_ff == ST_RUN) else $error("write did not start conversion");
	a_off_stops: assert property (@(posedge clk) disable iff (!rst_n)
		sc1_wr && !wr_ch_on |=> (!cv.busy && !conv_power_on) [*3]) else $error("converter left running");
	a_flag_plain: assert property (@(posedge clk) disable iff (!rst_n)
		cv.done && !cmp_en_ff ##1 !$past(wr_pend_ff && addr_ff == OFS_SC2) |=> flag_ff) else $error("flag not set on done");
	a_flag_cmp: assert property (@(posedge clk) disable iff (!rst_n)
		done_d_ff && cmp_en_ff && !cmp_hit |=> flag_ff == $past(flag_ff) || !flag_ff) else $error("flag set on miss");
	a_flag_cleared: assert property (@(posedge clk) disable iff (!rst_n)
		(sc1_wr || resl_rd) && !flag_set |=> !flag_ff) else $error("flag not cleared");
	a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
		flag_set && ien_ff && imsk_ff[IRQ_DONE_BIT] |=> irq && ists_ff[IRQ_DONE_BIT]) else $error("no interrupt");
	a_single_idle: assert property (@(posedge clk) disable iff (!rst_n)
		cv.done && !cont_ff && !sc1_wr |=> !cv.busy && !conv_power_on) else $error("single kept converting");
	a_cont_back: assert property (@(posedge clk) disable iff (!rst_n)
		cv.done && cont_ff && st_ff == ST_RUN && !sc1_wr |=> cv.busy ##1 (cv.busy || $past(sc1_wr)))
		else $error("continuous stopped");
	a_trig_start: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(trig_s3_ff) && trig_s2_ff && !trig_lvl_ff && st_ff == ST_ARMED && trig_sel_ff && !sc1_wr |=> cv.busy)
		else $error("trigger lost");
	a_mux_map: assert property (@(posedge clk) disable iff (!rst_n)
		ch_ff == CH_REFERENCE_HIGH |-> ref_high_sel && !ref_low_sel && !input_isolate) else $error("channel map wrong");
endmodule : adcc_top

// *** common/adcc_pkg.sv ***
// constants and types shared by the conversion control block
package adcc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_SC1 = 8'h00;
	localparam logic [7:0] OFS_SC2 = 8'h04;
	localparam logic [7:0] OFS_RESH = 8'h08;
	localparam logic [7:0] OFS_RESL = 8'h0c;
	localparam logic [7:0] OFS_CMPV = 8'h10;
	localparam logic [7:0] OFS_ISTS = 8'h14;
	localparam logic [7:0] OFS_IMSK = 8'h18;
	// status/control 1 fields
	localparam int SC1_FLAG_BIT = 7;
	localparam int SC1_IEN_BIT = 6;
	localparam int SC1_CONT_BIT = 5;
	localparam int SC1_CH_MSB = 4;
	// status/control 2 fields
	localparam int SC2_ACT_BIT = 7;
	localparam int SC2_TRIG_BIT = 6;
	localparam int SC2_CMPEN_BIT = 5;
	localparam int SC2_CMPGT_BIT = 4;
	// interrupt status fields
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ABORT_BIT = 1;
	localparam int IRQ_BITS = 2;
	// channel codes
	localparam logic [4:0] CH_LAST_AIN = 5'h1b;
	localparam logic [4:0] CH_RSVD = 5'h1c;
	localparam logic [4:0] CH_REFERENCE_HIGH = 5'h1d;
	localparam logic [4:0] CH_REFERENCE_LOW = 5'h1e;
	localparam logic [4:0] CH_OFF = 5'h1f;
	// reset values
	localparam logic [4:0] CH_RESET = 5'h1f;
	localparam logic [9:0] CMPV_RESET = 10'h000;
	// widths and timing
	localparam int RES_W = 10;
	localparam int CONV_CYCLES_DFLT = 20;
	// control states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN = 2'b10
	} adcc_state_e;
	// kind of source picked by the channel code
	typedef enum logic [2:0] {
		SRC_AIN = 3'b000,
		SRC_RSVD = 3'b001,
		SRC_REFH = 3'b010,
		SRC_REFL = 3'b011,
		SRC_OFF = 3'b100
	} adcc_src_e;
endpackage : adcc_pkg

// *** common/adcc_conv_if.sv ***
// carrier between controller and conversion sequencer
`timescale 1ns/1ns
interface adcc_conv_if;
	logic start;
	logic abort;
	logic busy;
	logic done;
	logic [9:0] result;
	modport ctl (output start, output abort, input busy, input done, input result);
	modport seq (input start, input abort, output busy, output done, output result);
endinterface : adcc_conv_if

// *** rtl/adcc_seq.sv ***
// conversion sequencer: times one successive approximation and latches its result
`timescale 1ns/1ns
module adcc_seq
	import adcc_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DFLT
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// controller side
	adcc_conv_if.seq cv,
	// analog converter answer
	input wire logic [9:0] ana_result
);
	logic [7:0] cnt_ff;
	logic busy_ff;
	logic [9:0] res_ff;

	// done is combinational so an abort in the last cycle cannot hide it
	assign cv.done = busy_ff && (cnt_ff == 8'(CONV_CYCLES - 1));
	assign cv.busy = busy_ff;
	assign cv.result = res_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_ff <= 1'b0;
			cnt_ff <= 8'h00;
		end
		else if (cv.start)
		begin
			busy_ff <= 1'b1;
			cnt_ff <= 8'h00;
		end
		else if (cv.abort || cv.done)
			busy_ff <= 1'b0;
		else if (busy_ff)
			cnt_ff <= cnt_ff + 8'h01;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			res_ff <= 10'h000;
		else if (cv.done)
			res_ff <= ana_result;
	end

	a_start_clears: assert property (@(posedge clk) disable iff (!rst_n)
		cv.start |=> busy_ff && cnt_ff == 8'h00) else $error("start did not restart timer");
endmodule : adcc_seq

// *** rtl/adcc_cmp.sv ***
// compare function: less-than or greater-or-equal against a stored level
`timescale 1ns/1ns
module adcc_cmp
	import adcc_pkg::*;
(
	// operands
	input wire logic [9:0] result,
	input wire logic [9:0] level,
	// mode
	input wire logic greater_eq,
	// outcome
	output logic hit
);
	always_comb
	begin
		if (greater_eq)
			hit = (result >= level);
		else
			hit = (result < level);
	end
endmodule : adcc_cmp

// *** test/test_adc_conversion_control.sv ***
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module test_adc_conversion_control;
	import adcc_pkg::*;
	// short conversions keep the run brief
	localparam int CONV = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hardware_trigger_in = 1'b0;
	logic [9:0] ana_result = 10'h0;
	logic hreadyout, hresp, irq, conv_power_on, conv_active, ref_high_sel, ref_low_sel, input_isolate;
	logic [31:0] hrdata;
	logic [4:0] ain_select;
	logic [31:0] v;
	logic [9:0] r;
	logic ge;
	int err_count = 0;
	int check_count = 0;

	adcc_top #(.CONV_CYCLES(CONV)) adcc_top_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hardware_trigger_in(hardware_trigger_in),
		.ana_result(ana_result), .conv_power_on(conv_power_on), .conv_active(conv_active),
		.ain_select(ain_select), .ref_high_sel(ref_high_sel), .ref_low_sel(ref_low_sel),
		.input_isolate(input_isolate), .irq(irq));

	initial
	begin
		forever #10 clk = ~clk;
	end

	// {isolate, low ref, high ref, analog input}
	function automatic logic [7:0] exp_route(input logic [4:0] c);
		return {c == 5'h1f || c == 5'h1c, c == 5'h1e, c == 5'h1d, (c <= 5'h1b) ? c : 5'h00};
	endfunction : exp_route

	function automatic logic exp_hit(input logic [9:0] res, input logic [9:0] lvl, input logic gte);
		return gte ? (res >= lvl) : (res < lvl);
	endfunction : exp_hit

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk_bit

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// waits for hready at a rising edge, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		do @(posedge clk); while (hreadyout !== 1'b1 && n++ < 50);
		if (hreadyout !== 1'b1)
			err_count++;
	endtask : wait_rdy

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		ahb(1'b0, a, 32'h0, d);
	endtask : rd

	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (conv_active !== lvl && n++ < 100)
			@(posedge clk);
		chk_bit(conv_active, lvl);
	endtask : wait_busy

	// one software-started conversion, then the done flag
	task automatic run_conv(input logic [31:0] ctl, input logic [9:0] res, input logic exp_flag);
		logic [31:0] x;
		ana_result <= res;
		wr(OFS_SC1, ctl);
		wait_busy(1'b1);
		chk_bit(conv_power_on, 1'b1);
		wait_busy(1'b0);
		repeat (3) @(posedge clk);
		rd(OFS_SC1, x);
		chk_bit(x[SC1_FLAG_BIT], exp_flag);
	endtask : run_conv

	initial
	begin
		#(20 * 20000);
		err_count++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(73780));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk_bit(input_isolate, 1'b1);
		chk_bit(irq, 1'b0);
		chk_bit(hresp, 1'b0);
		rd(OFS_SC1, v);
		chk_word(v, 32'h1f);
		rd(OFS_SC2, v);
		chk_word(v, 32'h0);
		wr(8'h1c, 32'hffffffff);
		rd(8'h1c, v);
		chk_word(v, 32'h0);
		// every channel code, single software conversions
		for (int c = 0; c < 32; c++)
		begin
			r = 10'($urandom);
			if (c == 31)
			begin
				wr(OFS_SC1, 32'h9f);
				repeat (2 * CONV) @(posedge clk);
				chk_bit(conv_active, 1'b0);
				chk_bit(conv_power_on, 1'b0);
				rd(OFS_SC1, v);
				chk_word(v, 32'h1f);
			end
			else
			begin
				run_conv(32'(c), r, 1'b1);
				chk_bit(conv_power_on, 1'b0);
				rd(OFS_RESH, v);
				chk_word(v, {30'h0, r[9:8]});
				rd(OFS_RESL, v);
				chk_word(v, {24'h0, r[7:0]});
				rd(OFS_SC1, v);
				chk_word(v, 32'(c));
			end
			chk_word({24'h0, input_isolate, ref_low_sel, ref_high_sel, ain_select}, {24'h0, exp_route(5'(c))});
		end
		// interrupt: enable bit, mask, write-one-to-clear
		run_conv(32'h43, 10'($urandom), 1'b1);
		chk_bit(irq, 1'b0);
		rd(OFS_ISTS, v);
		chk_word(v, 32'h1);
		wr(OFS_IMSK, 32'h1);
		@(posedge clk);
		chk_bit(irq, 1'b1);
		wr(OFS_ISTS, 32'h1);
		@(posedge clk);
		chk_bit(irq, 1'b0);
		run_conv(32'h43, 10'($urandom), 1'b1);
		chk_bit(irq, 1'b1);
		wr(OFS_ISTS, 32'h1);
		run_conv(32'h03, 10'($urandom), 1'b1);
		rd(OFS_ISTS, v);
		chk_word(v, 32'h0);
		// compare both ways around the level, boundaries first
		wr(OFS_CMPV, 32'h200);
		for (int k = 0; k < 8; k++)
		begin
			r = (k < 4) ? (k[1] ? 10'h200 : 10'h1ff) : 10'($urandom);
			ge = k[0];
			wr(OFS_SC2, {26'h0, 1'b1, ge, 4'h0});
			run_conv(32'h00, r, exp_hit(r, 10'h200, ge));
		end
		wr(OFS_SC2, 32'h0);
		run_conv(32'h00, 10'h3ff, 1'b1);
		// restart while busy
		wr(OFS_ISTS, 32'h3);
		wr(OFS_SC1, 32'h01);
		run_conv(32'h02, ana_result, 1'b1);
		rd(OFS_ISTS, v);
		chk_word(v, 32'h2);
		// continuous software conversions, then stop
		ana_result <= 10'($urandom);
		wr(OFS_SC1, 32'h25);
		repeat (4 * CONV) @(posedge clk);
		chk_bit(conv_active, 1'b1);
		rd(OFS_RESL, v);
		repeat (CONV + 4) @(posedge clk);
		rd(OFS_SC1, v);
		chk_bit(v[SC1_FLAG_BIT], 1'b1);
		wr(OFS_SC1, 32'h3f);
		repeat (3 * CONV) @(posedge clk);
		chk_bit(conv_active, 1'b0);
		chk_bit(conv_power_on, 1'b0);
		// hardware trigger: a write arms, a rise starts
		wr(OFS_SC2, 32'h40);
		wr(OFS_SC1, 32'h02);
		repeat (3 * CONV) @(posedge clk);
		chk_bit(conv_active, 1'b0);
		hardware_trigger_in <= 1'b1;
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (3 * CONV) @(posedge clk);
		chk_bit(conv_active, 1'b0);
		rd(OFS_SC1, v);
		chk_bit(v[SC1_FLAG_BIT], 1'b1);
		hardware_trigger_in <= 1'b0;
		wr(OFS_SC1, 32'h22);
		repeat (5) @(posedge clk);
		hardware_trigger_in <= 1'b1;
		wait_busy(1'b1);
		repeat (4 * CONV) @(posedge clk);
		chk_bit(conv_active, 1'b1);
		wr(OFS_SC1, 32'h1f);
		repeat (3 * CONV) @(posedge clk);
		chk_bit(conv_active, 1'b0);
		end_of_test();
	end
endmodule : test_adc_conversion_control
